// file: pmr_pkg.sv
// Constants, register map and field layout of the power monitor result scaling block.
// Assumes one 250 MHz clock and an APB master with 32-bit data and byte addresses.
// What this block does
// - Shunt weight follows range select bit.
// - Shunt result is 16-bit signed.
// - Bus result 16-bit, never negative, 85 V.
// - Temperature result 12-bit signed, 125 mC.
// - Current recomputed after each shunt result.
// - Zero calibration gives zero current.
// - Current scaling uses fixed internal constant.
// - Power result is 24-bit unsigned.
// - Eight conversion times, 50 us shortest.
// - Output period is conversion time times count.
package pmr_pkg;

  localparam int unsigned CLK_FREQ_MHZ = 250;
  localparam int unsigned CONV_MIN_US = 50;
  localparam int unsigned CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SHUNT_CAL = 8'h04;
  localparam logic [7:0] OFS_SHUNT_V = 8'h08;
  localparam logic [7:0] OFS_BUS_V = 8'h0c;
  localparam logic [7:0] OFS_DIE_TEMP = 8'h10;
  localparam logic [7:0] OFS_CURRENT = 8'h14;
  localparam logic [7:0] OFS_POWER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  localparam int unsigned CFG_W = 8;
  localparam int unsigned CFG_RANGE_BIT = 0;
  localparam int unsigned CFG_CT_LSB = 1;
  localparam int unsigned CFG_AVG_LSB = 4;
  localparam int unsigned CFG_EN_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h8a;
  localparam int unsigned STAT_NEW_BIT = 0;
  localparam int unsigned STAT_EN_BIT = 1;

  localparam int unsigned RAW_SHUNT_W = 18;
  localparam int unsigned RAW_BUS_W = 16;
  localparam int unsigned TEMP_W = 12;
  localparam int unsigned TEMP_LSB = 4;
  localparam int unsigned CAL_W = 15;
  localparam int unsigned PWR_W = 24;
  localparam int unsigned RANGE0_SHIFT = 2;
  localparam logic [15:0] BUS_MAX = 16'h6a40;
  localparam int unsigned CUR_SHIFT = 11;
  localparam int unsigned PWR_SHIFT = 8;

endpackage : pmr_pkg

// file: pmr_result_scaling.sv
// Result formatting, averaging, current and power calculation behind an APB register file.
// Assumes the ADC front end delivers raw codes on sys_clk, valid at each conversion tick.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module pmr_result_scaling
  import pmr_pkg::*;
#(
  parameter int unsigned CLK_PER_US = CLK_FREQ_MHZ
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [RAW_SHUNT_W-1:0] adc_shunt_raw,
  input wire logic signed [RAW_BUS_W-1:0] adc_bus_raw,
  input wire logic signed [TEMP_W-1:0] adc_temp_raw,
  output logic conv_tick
);

  function automatic logic signed [15:0] pmr_sat16(input logic signed [39:0] x);
    if (x > 40'sh0000007fff) begin
      return 16'sh7fff;
    end else if (x < -40'sh0000008000) begin
      return 16'sh8000;
    end
    return x[15:0];
  endfunction : pmr_sat16

  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic conv_tick_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic [CAL_W-1:0] cal_reg;
  logic [1:0] status_reg;
  logic signed [15:0] shunt_res_reg;
  logic [15:0] bus_res_reg;
  logic [15:0] temp_res_reg;
  logic signed [15:0] cur_reg;
  logic [PWR_W-1:0] pwr_reg;
  logic res_upd_reg;
  logic cur_upd_reg;
  logic pwr_upd_reg;
  logic [31:0] conv_cnt_reg;
  logic [10:0] samp_cnt_reg;
  logic signed [27:0] sh_acc_reg;
  logic signed [25:0] bs_acc_reg;
  logic signed [21:0] tp_acc_reg;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign conv_tick = conv_tick_reg;

  logic access;
  logic wr_fire;
  logic rd_fire;
  logic cfg_wr;
  logic addr_hit;
  logic [31:0] rd_data;
  logic enabled;
  logic range_sel;
  logic [2:0] ct_sel;
  logic [2:0] avg_sel;
  logic [31:0] conv_cyc;
  logic [10:0] avg_last;
  logic last;
  logic signed [27:0] sh_sum;
  logic signed [25:0] bs_sum;
  logic signed [21:0] tp_sum;
  logic signed [27:0] sh_avg;
  logic signed [25:0] bs_avg;
  logic signed [21:0] tp_avg;
  logic signed [39:0] cur_prod;
  logic [16:0] cur_mag;
  logic [32:0] pwr_prod;

  assign access = psel && penable && !pready_reg;
  assign wr_fire = psel && penable && pready_reg && pwrite;
  assign rd_fire = psel && penable && pready_reg && !pwrite;
  assign cfg_wr = wr_fire && (paddr == OFS_CONFIG);
  assign enabled = cfg_reg[CFG_EN_BIT];
  assign range_sel = cfg_reg[CFG_RANGE_BIT];
  assign ct_sel = cfg_reg[CFG_CT_LSB +: 3];
  assign avg_sel = cfg_reg[CFG_AVG_LSB +: 3];
  assign conv_cyc = CONV_US[ct_sel] * CLK_PER_US;
  assign avg_last = 11'((32'd1 << AVG_SHIFT[avg_sel]) - 32'd1);
  assign last = samp_cnt_reg >= avg_last;
  assign sh_sum = sh_acc_reg + 28'(adc_shunt_raw);
  assign bs_sum = bs_acc_reg + 26'(adc_bus_raw);
  assign tp_sum = tp_acc_reg + 22'(adc_temp_raw);
  assign sh_avg = sh_sum >>> AVG_SHIFT[avg_sel];
  assign bs_avg = bs_sum >>> AVG_SHIFT[avg_sel];
  assign tp_avg = tp_sum >>> AVG_SHIFT[avg_sel];
  // The fixed 819.2e6 scaling and the shunt LSB fold into one right shift of the product.
  assign cur_prod = (40'(shunt_res_reg) * 40'(signed'({1'b0, cal_reg}))) >>> CUR_SHIFT;
  assign cur_mag = cur_reg[15] ? 17'(-18'(cur_reg)) : 17'(cur_reg);
  assign pwr_prod = (33'(cur_mag) * 33'(bus_res_reg)) >> PWR_SHIFT;

  always_comb begin
    addr_hit = 1'b1;
    rd_data = '0;
    unique case (paddr)
      OFS_CONFIG: rd_data = 32'(cfg_reg);
      OFS_SHUNT_CAL: rd_data = 32'(cal_reg);
      OFS_SHUNT_V: rd_data = 32'(unsigned'(shunt_res_reg));
      OFS_BUS_V: rd_data = 32'(bus_res_reg);
      OFS_DIE_TEMP: rd_data = 32'(temp_res_reg);
      OFS_CURRENT: rd_data = 32'(unsigned'(cur_reg));
      OFS_POWER: rd_data = 32'(pwr_reg);
      OFS_STATUS: rd_data = 32'(status_reg);
      default: addr_hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle, read data is latched with it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access;
      if (access) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_reg <= !addr_hit;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_reg <= CFG_RESET;
      cal_reg <= '0;
    end else if (wr_fire) begin
      if (paddr == OFS_CONFIG) begin
        cfg_reg <= pwdata[CFG_W-1:0];
      end
      if (paddr == OFS_SHUNT_CAL) begin
        cal_reg <= pwdata[CAL_W-1:0];
      end
    end
  end

  // Only the bit value that was reported is cleared, so a result landing between the
  // data latch and the completing edge stays flagged; a fresh set also wins outright.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_reg <= '0;
    end else begin
      status_reg[STAT_EN_BIT] <= enabled;
      if (pwr_upd_reg) begin
        status_reg[STAT_NEW_BIT] <= 1'b1;
      end else if (rd_fire && paddr == OFS_STATUS && prdata_reg[STAT_NEW_BIT]) begin
        status_reg[STAT_NEW_BIT] <= 1'b0;
      end
    end
  end

  // A configuration write restarts the conversion period and the averaging window.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enabled || cfg_wr) begin
      conv_cnt_reg <= '0;
      conv_tick_reg <= 1'b0;
    end else begin
      conv_tick_reg <= conv_cnt_reg == 32'd0;
      conv_cnt_reg <= (conv_cnt_reg == 32'd0) ? conv_cyc - 32'd1 : conv_cnt_reg - 32'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enabled || cfg_wr) begin
      samp_cnt_reg <= '0;
      sh_acc_reg <= '0;
      bs_acc_reg <= '0;
      tp_acc_reg <= '0;
    end else if (conv_tick_reg) begin
      samp_cnt_reg <= last ? 11'h0 : samp_cnt_reg + 11'h1;
      sh_acc_reg <= last ? 28'sh0000000 : sh_sum;
      bs_acc_reg <= last ? 26'sh0 : bs_sum;
      tp_acc_reg <= last ? 22'sh0 : tp_sum;
    end
  end

  // All three measured results load on the same edge from the finished average.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shunt_res_reg <= '0;
      bus_res_reg <= '0;
      temp_res_reg <= '0;
      res_upd_reg <= 1'b0;
    end else begin
      res_upd_reg <= conv_tick_reg && last && enabled && !cfg_wr;
      if (conv_tick_reg && last && enabled && !cfg_wr) begin
        shunt_res_reg <= range_sel ? pmr_sat16(40'(sh_avg))
                                   : pmr_sat16(40'(sh_avg >>> RANGE0_SHIFT));
        if (bs_avg < 26'sh0) begin
          bus_res_reg <= 16'h0000;
        end else if (bs_avg > 26'(BUS_MAX)) begin
          bus_res_reg <= BUS_MAX;
        end else begin
          bus_res_reg <= bs_avg[15:0];
        end
        temp_res_reg <= {tp_avg[TEMP_W-1:0], 4'h0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_reg <= '0;
      cur_upd_reg <= 1'b0;
    end else begin
      cur_upd_reg <= res_upd_reg;
      if (res_upd_reg) begin
        cur_reg <= (cal_reg == '0) ? 16'sh0000 : pmr_sat16(cur_prod);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwr_reg <= '0;
      pwr_upd_reg <= 1'b0;
    end else begin
      pwr_upd_reg <= cur_upd_reg;
      if (cur_upd_reg) begin
        pwr_reg <= (pwr_prod > 33'h0ff_ffff) ? 24'hff_ffff : pwr_prod[PWR_W-1:0];
      end
    end
  end

  // Helper counters read only by the checks below.
  // The window counter times whole averaging windows in cycles, so a wrong sample
  // count shows up as a wrong output period rather than agreeing with itself.
  logic [31:0] gap_cnt_reg;
  logic gap_ok_reg;
  logic [31:0] win_cnt_reg;
  logic win_ok_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enabled || cfg_wr) begin
      gap_cnt_reg <= '0;
      gap_ok_reg <= 1'b0;
      win_cnt_reg <= '0;
      win_ok_reg <= 1'b0;
    end else begin
      gap_cnt_reg <= conv_tick_reg ? 32'd0 : gap_cnt_reg + 32'd1;
      win_cnt_reg <= (conv_tick_reg && last) ? 32'd0 : win_cnt_reg + 32'd1;
      if (conv_tick_reg) begin
        gap_ok_reg <= 1'b1;
      end
      if (conv_tick_reg && last) begin
        win_ok_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence result_chain_s;
    res_upd_reg ##1 cur_upd_reg ##1 pwr_upd_reg;
  endsequence
  sequence avg_done_s;
    conv_tick_reg && last && enabled && !cfg_wr;
  endsequence

  conv_period_a: assert property (conv_tick_reg && gap_ok_reg |-> gap_cnt_reg == conv_cyc - 32'd1)
    else $error("conversion ticks not one conversion time apart");
  conv_min_a: assert property (conv_tick_reg |=> !conv_tick_reg)
    else $error("conversion tick lasted more than one cycle");
  avg_count_a: assert property (avg_done_s ##0 win_ok_reg |->
      win_cnt_reg == ((32'd1 << AVG_SHIFT[avg_sel]) * conv_cyc) - 32'd1)
    else $error("output period not conversion time times averaging count");
  shunt_scale_a: assert property (avg_done_s ##0 !range_sel |=>
      shunt_res_reg == pmr_sat16(40'($past(sh_avg) >>> RANGE0_SHIFT)))
    else $error("wide range shunt result not scaled to 5 uV steps");
  shunt_sign_a: assert property (avg_done_s ##0 (sh_avg < 28'sh0000000) |=> shunt_res_reg[15])
    else $error("negative shunt average reported as positive");
  bus_range_a: assert property (res_upd_reg |-> bus_res_reg <= BUS_MAX)
    else $error("bus result above full scale");
  temp_pack_a: assert property (res_upd_reg |-> temp_res_reg[TEMP_LSB-1:0] == 4'h0)
    else $error("temperature low nibble not zero");
  cur_follow_a: assert property (avg_done_s |=> result_chain_s)
    else $error("current and power did not follow the shunt result");
  cal_zero_a: assert property (res_upd_reg && cal_reg == '0 |=> cur_reg == 16'sh0000)
    else $error("zero calibration gave a nonzero current");
  cur_scale_a: assert property (res_upd_reg && cal_reg != '0 |=>
      cur_reg == pmr_sat16($past(cur_prod)))
    else $error("current not scaled by calibration and shift");
  pwr_sign_a: assert property (cur_upd_reg && cur_reg == 16'sh0000 |=> pwr_reg == 24'h00_0000)
    else $error("power nonzero with zero current");
  result_hold_a: assert property (!(conv_tick_reg && last && enabled && !cfg_wr) |=>
      $stable(shunt_res_reg) && $stable(bus_res_reg) && $stable(temp_res_reg))
    else $error("a measured result changed outside its update");

endmodule : pmr_result_scaling

// file: tb_power_monitor_result_scaling.sv
// Self-checking testbench for the power monitor result scaling block.
// Assumes pmr_pkg is compiled first; the design runs with one cycle per microsecond.
`timescale 1ns/1ps
module tb_power_monitor_result_scaling
  import pmr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [17:0] shunt_base = 18'h0;
  logic signed [17:0] shunt_ofs = 18'h0;
  logic signed [17:0] shunt_step = 18'h0;
  logic signed [17:0] adc_shunt_raw;
  logic signed [15:0] adc_bus_raw = 16'h0;
  logic signed [11:0] adc_temp_raw = 12'h0;
  logic conv_tick;
  int tick_cnt = 0;
  int tick_base = 0;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;

  assign adc_shunt_raw = shunt_base + shunt_ofs;

  pmr_result_scaling #(.CLK_PER_US(1)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_shunt_raw(adc_shunt_raw), .adc_bus_raw(adc_bus_raw),
    .adc_temp_raw(adc_temp_raw), .conv_tick(conv_tick));

  always #2 sys_clk = ~sys_clk;

  // The ramp lets an average be told apart from any single sample.
  always @(posedge sys_clk) begin
    if (conv_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (shunt_step == 0) shunt_ofs <= 18'h0;
    else if (conv_tick === 1'b1) shunt_ofs <= shunt_ofs + shunt_step;
  end

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rc

  // A CONFIG write restarts the period counter, so ticks are counted from here.
  task automatic cfg(input logic [7:0] v);
    apb(1'b1, OFS_CONFIG, {24'h0, v});
    @(negedge sys_clk);
    tick_base = tick_cnt;
  endtask : cfg

  task automatic wait_ticks(input int n);
    int k;
    for (k = 0; k < 20000 && tick_cnt - tick_base < n; k++) @(negedge sys_clk);
    if (k >= 20000) begin
      error_cnt++;
      $display("mismatch at %0t: no conversion tick", $time);
    end
    repeat (6) @(posedge sys_clk);
  endtask : wait_ticks

  task automatic t_reset();
    rc(OFS_CONFIG, 32'h8a);
    rc(OFS_SHUNT_CAL, 32'h0);
    apb(1'b1, OFS_SHUNT_CAL, 32'hffff);
    rc(OFS_SHUNT_CAL, 32'h7fff);
    apb(1'b1, OFS_SHUNT_V, 32'h1234);
    rc(OFS_SHUNT_V, 32'h0);
    rc(OFS_POWER, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    rc(OFS_STATUS, 32'h3);
  endtask : t_reset

  task automatic t_period();
    int k;
    int n;
    for (k = 0; k < 8; k++) begin
      cfg(8'h80 | 8'(k << 1));
      n = 0;
      while (conv_tick !== 1'b1 && n < 5000) begin
        @(negedge sys_clk);
        n++;
      end
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (conv_tick !== 1'b1 && n < 5000);
      chk(32'(n), CONV_US[k]);
    end
  endtask : t_period

  task automatic t_scale(input logic rng, input logic [17:0] s, input logic [15:0] b, input logic [11:0] t,
                         input logic [31:0] es, input logic [31:0] eb, input logic [31:0] et);
    @(posedge sys_clk);
    shunt_base <= s;
    adc_bus_raw <= b;
    adc_temp_raw <= t;
    cfg({7'h40, rng});
    wait_ticks(1);
    rc(OFS_SHUNT_V, es);
    rc(OFS_BUS_V, eb);
    rc(OFS_DIE_TEMP, et);
  endtask : t_scale

  task automatic t_calc();
    // The narrow range runs with four times the wide-range constant of 0x40.
    apb(1'b1, OFS_SHUNT_CAL, 32'h100);
    @(posedge sys_clk);
    shunt_base <= 18'd1000;
    adc_bus_raw <= 16'h1000;
    cfg(8'h81);
    wait_ticks(1);
    rc(OFS_CURRENT, 32'h7d);
    rc(OFS_POWER, 32'h7d0);
    shunt_base <= -18'sd1000;
    wait_ticks(2);
    rc(OFS_CURRENT, 32'hff83);
    rc(OFS_POWER, 32'h7d0);
    apb(1'b1, OFS_SHUNT_CAL, 32'h0);
    wait_ticks(3);
    rc(OFS_CURRENT, 32'h0);
    // Full-scale inputs drive the current product far past 0x7fff, so the result saturates there.
    apb(1'b1, OFS_SHUNT_CAL, 32'h7fff);
    shunt_base <= 18'h7fff;
    adc_bus_raw <= 16'h6a40;
    wait_ticks(4);
    rc(OFS_CURRENT, 32'h7fff);
    rc(OFS_POWER, 32'((64'd32767 * 64'd27200) >> 8));
  endtask : t_calc

  task automatic t_avg();
    @(posedge sys_clk);
    shunt_base <= 18'd200;
    cfg(8'h91);
    shunt_step = 18'd4;
    apb(1'b0, OFS_STATUS, 32'h0);
    wait_ticks(3);
    rc(OFS_STATUS, 32'h2);
    wait_ticks(4);
    rc(OFS_STATUS, 32'h3);
    rc(OFS_SHUNT_V, 32'hce);
    wait_ticks(7);
    rc(OFS_STATUS, 32'h2);
    wait_ticks(8);
    rc(OFS_STATUS, 32'h3);
    rc(OFS_SHUNT_V, 32'hde);
    shunt_step = 18'd0;
  endtask : t_avg

  // With the enable bit clear no conversion runs and the enable mirror reads low.
  task automatic t_off();
    cfg(8'h01);
    repeat (60) @(posedge sys_clk);
    chk(32'(tick_cnt - tick_base), 32'h0);
    rc(OFS_STATUS, 32'h0);
  endtask : t_off

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_period();
    t_scale(1'b1, -18'sd1000, -16'sd5, -12'sd8, 32'hfc18, 32'h0, 32'hff80);
    t_scale(1'b0, -18'sd1000, 16'h7000, 12'd100, 32'hff06, 32'h6a40, 32'h0640);
    t_scale(1'b1, 18'h1ffff, 16'h1000, 12'h7ff, 32'h7fff, 32'h1000, 32'h7ff0);
    t_scale(1'b0, 18'h20000, 16'h6a40, 12'h800, 32'h8000, 32'h6a40, 32'h8000);
    t_calc();
    t_avg();
    t_off();
    summarize();
  end

  // The run needs well under 30,000 cycles; this limit leaves ample margin.
  initial begin
    #300000;
    error_cnt++;
    summarize();
  end
endmodule : tb_power_monitor_result_scaling
